// ---- shared/line_if_map.svh ----
/*
 * Constants of the multirate line interface core: alarm limits, error-rate
 * window, fifo depth and clock rate.
 * Assumes inclusion by bare name from design files.
 */
`ifndef LINE_IF_MAP_SVH
`define LINE_IF_MAP_SVH

// Core clock rate in Hz (period 50 ns)
`define CORE_CLK_HZ 20000000
// Stuck-clock limit in periods, inside the 20..32 band
`define LOC_LIMIT 24
// All-zero limit in line periods, inside the 20..32 band
`define LOS_LIMIT 24
// Error-rate window length in seconds
`define ERR_WINDOW_S 10
// Assumed rate of the error-rate clock in Hz
`define ERR_CLK_HZ 1000
// Window length in error-rate clock ticks
`define ERR_WINDOW_TICKS (`ERR_WINDOW_S * `ERR_CLK_HZ)
// Violations per window above which line quality is flagged
`define CV_THRESHOLD 3
// Receive elastic store depth in symbols
`define RX_FIFO_DEPTH 32
// Width of one line symbol (positive and negative mark)
`define SYM_W 2

`endif

// ---- shared/line_if_pkg.sv ----
/*
 * Types shared by the line interface core: line symbol and source selects.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package line_if_pkg;

   // One bipolar line symbol: a mark on the positive or negative rail
   typedef struct packed {
      logic pos;
      logic neg;
   } sym_s;

   // Where the terminal-side receive clock comes from
   typedef enum logic [1:0] {
      SRC_LINE,
      SRC_LOOP,
      SRC_AIS
   } src_e;

endpackage

// ---- rtl/sym_fifo.sv ----
/*
 * Flip-flop FIFO with valid/ready on both sides; width and depth are
 * parameters.
 * Assumes one clock, synchronous active-high reset and a clock enable.
 */
`timescale 1ns/1ps

module sym_fifo #(
   parameter int W = 2,
   parameter int DEPTH = 32
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);

   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem_q [DEPTH];       // Storage
   logic [AW-1:0] wr_q, wr_d;         // Write index
   logic [AW-1:0] rd_q, rd_d;         // Read index
   logic [AW:0] cnt_q, cnt_d;         // Fill level
   logic push, pop;

   // Honest full and empty straight from the level
   assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o = mem_q[rd_q];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   // Next pointers and level
   always_comb begin
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (push) begin
         wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
         rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   // Register state; storage needs no reset
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else if (ce_i) begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
         if (push) begin
            mem_q[wr_q] <= in_data_i;
         end
      end
   end

endmodule

// ---- rtl/stuck_monitor.sv ----
/*
 * Counts ticks while a signal shows no activity; raises an alarm when the
 * count reaches LIMIT and drops it on the first activity.
 * Assumes one clock, synchronous active-high reset and a clock enable.
 */
`timescale 1ns/1ps

module stuck_monitor #(
   parameter int LIMIT = 24
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   // Observation
   input wire logic tick_i,
   input wire logic active_i,
   // Result
   output logic alarm_o
);

   localparam int CW = $clog2(LIMIT + 1);

   logic [CW-1:0] cnt_q, cnt_d;   // Quiet ticks seen
   logic alarm_q, alarm_d;        // Alarm state

   assign alarm_o = alarm_q;

   // Activity clears at once; quiet ticks count up to the limit
   always_comb begin
      cnt_d = cnt_q;
      alarm_d = alarm_q;
      if (active_i) begin
         cnt_d = '0;
         alarm_d = 1'b0;
      end else if (tick_i && cnt_q != CW'(LIMIT)) begin
         cnt_d = cnt_q + 1'b1;
         alarm_d = (cnt_q == CW'(LIMIT - 1));
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cnt_q <= '0;
         alarm_q <= 1'b0;
      end else if (ce_i) begin
         cnt_q <= cnt_d;
         alarm_q <= alarm_d;
      end
   end

   property p_alarm_rise;
      @(posedge clk_i) disable iff (srst_i)
      ce_i && tick_i && !active_i && cnt_q == CW'(LIMIT - 1) |=> alarm_q;
   endproperty
   a_alarm_rise: assert property (p_alarm_rise)
      else $error("alarm missed at limit");

   property p_alarm_clear;
      @(posedge clk_i) disable iff (srst_i)
      ce_i && active_i |=> !alarm_q && cnt_q == '0;
   endproperty
   a_alarm_clear: assert property (p_alarm_clear)
      else $error("alarm kept after activity");

endmodule

// ---- rtl/line_if_core.sv ----
/*
 * Digital core of a multirate line interface: terminal rail/NRZ I/O, HDB3
 * codec, loopbacks, AIS, clock and signal loss alarms, line quality.
 * Assumes all clock-like inputs are sampled as synchronous levels by the
 * much faster core clock CLK_I; the slicer delivers line marks.
 */
// Summary of operation
// - Rail mode low bypasses codec, rails both ways
// - Rail mode high uses NRZ with HDB3
// - Receive data changes on receive clock falling edge
// - Receive disable low floats data and clocks
// - Rail mode also drives inverted receive clock
// - Transmit data taken on transmit clock rise
// - Stuck transmit clock drives loss alarm low
// - Clock loss after 20-32 periods, clears on edge
// - Transmit AIS low sends all ones
// - Transmit loopback feeds line output to receiver
// - Receive loopback sends receive data to line
// - Receive AIS replaces data, timed by reference
// - Pulse per violation outside HDB3 substitution
// - Count violations over 10 second window
// - Loss of signal shown on active-low alarm
// - Signal loss after 20-32 zeros, clears on return
// - Codec serves the 8448 and 34368 kbit/s rates
// - Line outputs are active low, one per polarity
`timescale 1ns/1ps
`include "line_if_map.svh"

module line_if_core #(
   parameter int LOC_LIMIT = `LOC_LIMIT,
   parameter int LOS_LIMIT = `LOS_LIMIT,
   parameter int WINDOW_TICKS = `ERR_WINDOW_TICKS,
   parameter int CV_THRESHOLD = `CV_THRESHOLD,
   parameter int FIFO_DEPTH = `RX_FIFO_DEPTH
) (
   // Clock, reset, enable
   input wire logic CLK_I,
   input wire logic SRST_I,
   input wire logic CE_I,
   // Mode and control levels
   input wire logic RAIL_MODE_SELECT_N_I,
   input wire logic RX_OUTPUT_DISABLE_N_I,
   input wire logic TX_ALARM_INSERT_N_I,
   input wire logic RX_ALARM_INSERT_N_I,
   input wire logic TX_LOOPBACK_N_I,
   input wire logic RX_LOOPBACK_N_I,
   // Sampled clocks
   input wire logic TX_CLOCK_IN_I,
   input wire logic RX_RECOVERED_CLOCK_I,
   input wire logic REFERENCE_CLOCK_I,
   input wire logic ERROR_RATE_CLOCK_I,
   // Terminal transmit data (positive rail doubles as NRZ data)
   input wire logic TX_POSITIVE_RAIL_I,
   input wire logic TX_NEGATIVE_RAIL_I,
   // Line receive marks from the slicer
   input line_if_pkg::sym_s RX_LINE_I,
   // Terminal receive side, each with its output enable
   output logic RX_POSITIVE_RAIL_O,
   output logic RX_POSITIVE_RAIL_OE_O,
   output logic RX_NEGATIVE_RAIL_O,
   output logic RX_NEGATIVE_RAIL_OE_O,
   output logic RX_CLOCK_OUT_O,
   output logic RX_CLOCK_OUT_OE_O,
   output logic RX_CLOCK_OUT_INV_O,
   output logic RX_CLOCK_OUT_INV_OE_O,
   // Line transmit, active low
   output logic LINE_TX_POSITIVE_N_O,
   output logic LINE_TX_NEGATIVE_N_O,
   // Alarms and monitors
   output logic CODE_VIOLATION_PULSE_O,
   output logic LINE_QUALITY_ALARM_O,
   output logic TX_CLOCK_LOSS_ALARM_N_O,
   output logic RX_SIGNAL_LOSS_ALARM_N_O
);
   import line_if_pkg::*;

   localparam int WW = $clog2(WINDOW_TICKS + 1);

   ////////////////////////////////////////////////////////////////////////
   // Edge sampling and source selection

   logic txc_q, rxc_q, ock_q, bec_q;    // Previous clock levels
   logic nrz, tx_lb, rx_lb, rx_ais;     // Decoded control levels
   logic rx_clk, out_clk;               // Selected clock levels
   logic tx_rise, rx_rise, out_fall, be_rise;
   src_e src;                           // Receive clock source
   sym_s rx_sym;                        // Symbol into the receiver
   sym_s line_q, line_d;                // Symbol on the line output

   assign nrz = RAIL_MODE_SELECT_N_I;
   assign tx_lb = !TX_LOOPBACK_N_I;
   assign rx_lb = !RX_LOOPBACK_N_I;
   assign rx_ais = !RX_ALARM_INSERT_N_I;

   // AIS overrides loopback, which overrides the line
   always_comb begin
      if (rx_ais) begin
         src = SRC_AIS;
      end else if (tx_lb) begin
         src = SRC_LOOP;
      end else begin
         src = SRC_LINE;
      end
   end

   // Loopback takes our own line output, the external line is ignored
   assign rx_clk = tx_lb ? TX_CLOCK_IN_I : RX_RECOVERED_CLOCK_I;
   assign rx_sym = tx_lb ? line_q : RX_LINE_I;

   // Reference clock times receive AIS
   always_comb begin
      case (src)
         SRC_AIS: out_clk = REFERENCE_CLOCK_I;
         SRC_LOOP: out_clk = TX_CLOCK_IN_I;
         SRC_LINE: out_clk = RX_RECOVERED_CLOCK_I;
         default: out_clk = RX_RECOVERED_CLOCK_I;
      endcase
   end

   assign tx_rise = TX_CLOCK_IN_I & ~txc_q;
   assign rx_rise = rx_clk & ~rxc_q;
   assign out_fall = ~out_clk & ock_q;
   assign be_rise = ERROR_RATE_CLOCK_I & ~bec_q;

   ////////////////////////////////////////////////////////////////////////
   // HDB3 encoder and line transmit

   logic [3:0] ed_q, ed_d;    // Pending marks, bit 3 leaves first
   logic [3:0] ev_q, ev_d;    // Violation positions
   logic [1:0] zc_q, zc_d;    // Zeros since last mark
   logic par_q, par_d;        // Odd marks since last violation
   logic pol_q, pol_d;        // Polarity of last mark sent
   logic tx_bit;              // Bit into the encoder
   sym_s enc;                 // Encoder output symbol

   // All ones while transmit AIS is asked for
   assign tx_bit = TX_ALARM_INSERT_N_I ? TX_POSITIVE_RAIL_I : 1'b1;

   // Substitution decided as the fourth zero enters, so the B can still
   // be placed three slots back before it leaves
   always_comb begin
      ed_d = {ed_q[2:0], tx_bit};
      ev_d = {ev_q[2:0], 1'b0};
      zc_d = zc_q;
      par_d = par_q;
      pol_d = pol_q;
      enc = '0;
      if (ev_q[3]) begin
         enc = pol_q ? sym_s'(2'b10) : sym_s'(2'b01);
      end else if (ed_q[3]) begin
         pol_d = ~pol_q;
         enc = pol_d ? sym_s'(2'b10) : sym_s'(2'b01);
      end
      if (tx_bit) begin
         zc_d = '0;
         par_d = ~par_q;
      end else if (zc_q == 2'h3) begin
         ev_d[0] = 1'b1;
         ed_d[3] = ~par_q;
         par_d = 1'b0;
         zc_d = '0;
      end else begin
         zc_d = zc_q + 2'h1;
      end
   end

   // Line output source: loopback, coded NRZ/AIS or raw rails
   always_comb begin
      line_d = line_q;
      if (rx_lb) begin
         if (rx_rise) begin
            line_d = rx_sym;
         end
      end else if (tx_rise) begin
         if (nrz || !TX_ALARM_INSERT_N_I) begin
            line_d = enc;
         end else begin
            line_d = {TX_POSITIVE_RAIL_I, TX_NEGATIVE_RAIL_I};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // HDB3 decoder and receive store

   logic [3:0] dw_q, dw_d;    // Decoded bits, bit 3 leaves first
   logic dpol_q, dpol_d;      // Polarity of last received mark
   logic cv_q, cv_d;          // Violation pulse
   logic mark, dstep;
   logic fin_ready, fout_valid;
   sym_s fin, fout;

   assign mark = rx_sym.pos | rx_sym.neg;
   // Stalls while the store is full
   assign dstep = rx_rise & fin_ready;

   // A repeated polarity is legal only as 000V or B00V
   always_comb begin
      dw_d = dw_q;
      dpol_d = dpol_q;
      cv_d = 1'b0;
      if (dstep) begin
         dw_d = {dw_q[2:0], mark};
         if (mark) begin
            dpol_d = rx_sym.pos;
            if (rx_sym.pos == dpol_q) begin
               dw_d[0] = 1'b0;
               if (dw_q[2:0] == 3'h4) begin
                  dw_d[3] = 1'b0;
               end else if (dw_q[2:0] != 3'h0) begin
                  dw_d[0] = 1'b1;
                  cv_d = nrz;
               end
            end
         end
      end
   end

   // Codec path in NRZ mode, raw rails in rail mode
   assign fin = nrz ? sym_s'({dw_q[3], 1'b0}) : rx_sym;

   sym_fifo #(
      .W(`SYM_W),
      .DEPTH(FIFO_DEPTH)
   ) u_store (
      .clk_i(CLK_I),
      .srst_i(SRST_I),
      .ce_i(CE_I),
      .in_valid_i(dstep),
      .in_ready_o(fin_ready),
      .in_data_i(fin),
      .out_valid_o(fout_valid),
      .out_ready_i(out_fall && !rx_ais),
      .out_data_o(fout)
   );

   ////////////////////////////////////////////////////////////////////////
   // Terminal receive outputs

   sym_s rd_q, rd_d;          // Receive data driven out
   logic aisp_q, aisp_d;      // Alternating mark for rail AIS
   logic oe_q, oe_n_q, oe_i_q;

   // Data moves only on the falling edge of the clock sent out
   always_comb begin
      rd_d = rd_q;
      aisp_d = aisp_q;
      if (out_fall) begin
         if (rx_ais) begin
            aisp_d = ~aisp_q;
            rd_d = nrz ? sym_s'(2'b10) : {aisp_q, ~aisp_q};
         end else if (fout_valid) begin
            rd_d = fout;
         end else begin
            rd_d = '0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Line quality window

   logic [WW-1:0] wc_q, wc_d;   // Ticks in window
   logic [15:0] vc_q, vc_d;     // Violations in window
   logic lq_q, lq_d;            // Quality flag
   logic wend;

   assign wend = be_rise && (wc_q == WW'(WINDOW_TICKS - 1));

   // Verdict once per window; a violation at the boundary opens the next
   always_comb begin
      wc_d = wc_q;
      vc_d = vc_q;
      lq_d = lq_q;
      if (be_rise) begin
         wc_d = wend ? '0 : wc_q + 1'b1;
      end
      if (wend) begin
         lq_d = (vc_q > 16'(CV_THRESHOLD));
         vc_d = {15'h0, cv_d};
      end else if (cv_d && vc_q != 16'hffff) begin
         vc_d = vc_q + 16'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Alarms

   logic loc, los;

   stuck_monitor #(.LIMIT(LOC_LIMIT)) u_loc (
      .clk_i(CLK_I),
      .srst_i(SRST_I),
      .ce_i(CE_I),
      .tick_i(1'b1),
      .active_i(TX_CLOCK_IN_I ^ txc_q),
      .alarm_o(loc)
   );

   stuck_monitor #(.LIMIT(LOS_LIMIT)) u_los (
      .clk_i(CLK_I),
      .srst_i(SRST_I),
      .ce_i(CE_I),
      .tick_i(rx_rise),
      .active_i(rx_rise && mark),
      .alarm_o(los)
   );

   ////////////////////////////////////////////////////////////////////////
   // State registers

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         {txc_q, rxc_q, ock_q, bec_q} <= 4'h0;
         line_q <= '0;
         {ed_q, ev_q} <= 8'h00;
         zc_q <= 2'h0;
         {par_q, pol_q, dpol_q, cv_q, aisp_q} <= 5'h00;
         dw_q <= 4'h0;
         rd_q <= '0;
         {oe_q, oe_n_q, oe_i_q} <= 3'h0;
         wc_q <= '0;
         vc_q <= 16'h0;
         lq_q <= 1'b0;
      end else if (CE_I) begin
         txc_q <= TX_CLOCK_IN_I;
         rxc_q <= rx_clk;
         ock_q <= out_clk;
         bec_q <= ERROR_RATE_CLOCK_I;
         line_q <= line_d;
         if (tx_rise) begin
            {ed_q, ev_q} <= {ed_d, ev_d};
            {zc_q, par_q, pol_q} <= {zc_d, par_d, pol_d};
         end
         {dw_q, dpol_q, cv_q} <= {dw_d, dpol_d, cv_d};
         {rd_q, aisp_q} <= {rd_d, aisp_d};
         oe_q <= RX_OUTPUT_DISABLE_N_I;
         oe_n_q <= RX_OUTPUT_DISABLE_N_I && !nrz;
         oe_i_q <= RX_OUTPUT_DISABLE_N_I && !nrz;
         {wc_q, vc_q, lq_q} <= {wc_d, vc_d, lq_d};
      end
   end

   assign RX_POSITIVE_RAIL_O = rd_q.pos;
   assign RX_NEGATIVE_RAIL_O = rd_q.neg;
   assign RX_POSITIVE_RAIL_OE_O = oe_q;
   assign RX_NEGATIVE_RAIL_OE_O = oe_n_q;
   assign RX_CLOCK_OUT_O = ock_q;
   assign RX_CLOCK_OUT_OE_O = oe_q;
   assign RX_CLOCK_OUT_INV_O = ~ock_q;
   assign RX_CLOCK_OUT_INV_OE_O = oe_i_q;
   assign LINE_TX_POSITIVE_N_O = ~line_q.pos;
   assign LINE_TX_NEGATIVE_N_O = ~line_q.neg;
   assign CODE_VIOLATION_PULSE_O = cv_q;
   assign LINE_QUALITY_ALARM_O = lq_q;
   assign TX_CLOCK_LOSS_ALARM_N_O = ~loc;
   assign RX_SIGNAL_LOSS_ALARM_N_O = ~los;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   property p_rx_float;
      @(posedge CLK_I) disable iff (SRST_I)
      CE_I && !RX_OUTPUT_DISABLE_N_I |=> !RX_POSITIVE_RAIL_OE_O
         && !RX_CLOCK_OUT_OE_O && !RX_CLOCK_OUT_INV_OE_O;
   endproperty
   a_rx_float: assert property (p_rx_float)
      else $error("receive outputs driven while disabled");

   property p_nrz_rn_off;
      @(posedge CLK_I) disable iff (SRST_I)
      CE_I && RAIL_MODE_SELECT_N_I |=> !RX_NEGATIVE_RAIL_OE_O;
   endproperty
   a_nrz_rn_off: assert property (p_nrz_rn_off)
      else $error("negative rail driven in NRZ mode");

   property p_data_on_fall;
      @(posedge CLK_I) disable iff (SRST_I)
      $changed(rd_q) |-> $fell(RX_CLOCK_OUT_O);
   endproperty
   a_data_on_fall: assert property (p_data_on_fall)
      else $error("receive data moved off the falling edge");

   property p_cv_pulse;
      @(posedge CLK_I) disable iff (SRST_I)
      CODE_VIOLATION_PULSE_O |-> $past(RAIL_MODE_SELECT_N_I)
         ##1 (!CODE_VIOLATION_PULSE_O || !$stable(CE_I) || CE_I);
   endproperty
   a_cv_pulse: assert property (p_cv_pulse)
      else $error("violation pulse in rail mode");

   property p_rx_loop;
      @(posedge CLK_I) disable iff (SRST_I)
      CE_I && rx_lb && rx_rise |=> LINE_TX_POSITIVE_N_O == !$past(rx_sym.pos)
         && LINE_TX_NEGATIVE_N_O == !$past(rx_sym.neg);
   endproperty
   a_rx_loop: assert property (p_rx_loop)
      else $error("receive loopback not on line output");

   property p_rx_ais;
      @(posedge CLK_I) disable iff (SRST_I)
      CE_I && rx_ais && nrz && out_fall |=> RX_POSITIVE_RAIL_O;
   endproperty
   a_rx_ais: assert property (p_rx_ais)
      else $error("receive AIS not all ones");

   property p_quality;
      @(posedge CLK_I) disable iff (SRST_I)
      CE_I && wend |=> LINE_QUALITY_ALARM_O == ($past(vc_q) > 16'(CV_THRESHOLD));
   endproperty
   a_quality: assert property (p_quality)
      else $error("line quality verdict wrong");

   property p_loc_clear;
      @(posedge CLK_I) disable iff (SRST_I)
      CE_I && (TX_CLOCK_IN_I != txc_q) |=> TX_CLOCK_LOSS_ALARM_N_O;
   endproperty
   a_loc_clear: assert property (p_loc_clear)
      else $error("clock loss alarm kept after an edge");

endmodule

// ---- tb/term_model.sv ----
/*
 * Terminal-side model: presents tx bits on its own tx clock and samples
 * the receive rails on the rising edge of the receive clock.
 * Assumes the core clock; drives on its falling edge.
 */
`timescale 1ns/1ps

module term_model (
   // Core clock
   input wire logic clk_i,
   // Receive side from the core
   input wire logic rxp_i,
   input wire logic rxn_i,
   input wire logic rxc_i,
   input wire logic pe_i,
   input wire logic ne_i,
   // Transmit side to the core
   output logic txc_o,
   output logic txp_o,
   output logic txn_o,
   // Captured symbol and its strobe
   output logic cap_o,
   output logic [1:0] sym_o
);
   logic c_q = 1'b0; // Last receive clock level
   // Undriven rails float, so a stale level never passes
   wire p_w = pe_i ? rxp_i : 1'bz;
   wire n_w = ne_i ? rxn_i : 1'bz;

   initial begin
      txc_o = 1'b0;
      txp_o = 1'b0;
      txn_o = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Sample on the rise, since the core launches on the fall
   always @(posedge clk_i) begin
      cap_o <= rxc_i & ~c_q & pe_i;
      sym_o <= {p_w, n_w};
      c_q <= rxc_i;
   end

   // One bit: data settles while the clock is low, held over the rise
   task automatic send(input logic p, input logic n);
      @(negedge clk_i);
      txp_o = p;
      txn_o = n;
      @(negedge clk_i);
      txc_o = 1'b1;
      repeat (2) @(negedge clk_i);
      txc_o = 1'b0;
   endtask
endmodule

// ---- tb/testbench.sv ----
/*
 * Self-checking bench of the line interface core: notes queued by the
 * drivers, compared by a monitor when results appear.
 * Assumes the terminal model and the shared package.
 */
`timescale 1ns/1ps

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
   err_total++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
   end end

module testbench;
   import line_if_pkg::*;
   typedef struct packed {logic [1:0] md; logic [1:0] v;} note_s;
   note_s txq[$]; // Line notes: md 0 exact, 1 relative, 2 skip
   sym_s rxq[$]; // Expected receive rails
   int err_total = 0, n_tests = 0, cv_cnt = 0;
   // Rail mode first, as the slowest rate wants it
   logic clk = 0, srst = 1, rail_n = 0, dis_n = 1, tai_n = 1, rai_n = 1;
   logic lbr_n = 1; // Receive loopback request
   logic rrc = 0, refc = 0, erc = 0, rise_q = 0, rise_qq = 0, tpv = 0;
   logic refp = 0; // Polarity of the reference mark
   sym_s rxl = '0;
   logic [31:0] rs = 32'h5c3cc583;
   logic rp, rpe, rn, rne, ck, cke, cki, ckie, lp_n, ln_n, cv, lq;
   logic loc_n, los_n, txc, txp, txn, cap;
   logic [1:0] csym;

   function automatic logic [31:0] xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction

   initial forever #25 clk = ~clk;
   // Error-rate tick every 10 cycles; short window keeps the run brief
   initial forever begin
      repeat (5) @(negedge clk);
      erc = ~erc;
   end

   line_if_core #(.WINDOW_TICKS(20)) dut (
      .CLK_I(clk), .SRST_I(srst), .CE_I(1'b1),
      .RAIL_MODE_SELECT_N_I(rail_n), .RX_OUTPUT_DISABLE_N_I(dis_n),
      .TX_ALARM_INSERT_N_I(tai_n), .RX_ALARM_INSERT_N_I(rai_n),
      .TX_LOOPBACK_N_I(1'b1), .RX_LOOPBACK_N_I(lbr_n),
      .TX_CLOCK_IN_I(txc), .RX_RECOVERED_CLOCK_I(rrc),
      .REFERENCE_CLOCK_I(refc), .ERROR_RATE_CLOCK_I(erc),
      .TX_POSITIVE_RAIL_I(txp), .TX_NEGATIVE_RAIL_I(txn), .RX_LINE_I(rxl),
      .RX_POSITIVE_RAIL_O(rp), .RX_POSITIVE_RAIL_OE_O(rpe),
      .RX_NEGATIVE_RAIL_O(rn), .RX_NEGATIVE_RAIL_OE_O(rne),
      .RX_CLOCK_OUT_O(ck), .RX_CLOCK_OUT_OE_O(cke),
      .RX_CLOCK_OUT_INV_O(cki), .RX_CLOCK_OUT_INV_OE_O(ckie),
      .LINE_TX_POSITIVE_N_O(lp_n), .LINE_TX_NEGATIVE_N_O(ln_n),
      .CODE_VIOLATION_PULSE_O(cv), .LINE_QUALITY_ALARM_O(lq),
      .TX_CLOCK_LOSS_ALARM_N_O(loc_n), .RX_SIGNAL_LOSS_ALARM_N_O(los_n));

   term_model u_term (.clk_i(clk), .rxp_i(rp), .rxn_i(rn), .rxc_i(ck),
      .pe_i(rpe & cke), .ne_i(rne), .txc_o(txc), .txp_o(txp),
      .txn_o(txn), .cap_o(cap), .sym_o(csym));

   ///////////////////////////////////////////////////////////////////////
   // Track tx rises as the core sees them; output lands with rise_q, checked a cycle later
   always @(posedge clk) begin
      rise_q <= txc & ~tpv & ~srst;
      rise_qq <= rise_q;
      tpv <= srst ? 1'b0 : txc;
   end

   // Monitor: settled outputs against the oldest note
   always @(negedge clk) begin
      note_s n;
      sym_s s;
      logic [1:0] g, e;
      g = {~lp_n, ~ln_n};
      if (rise_qq && txq.size() > 0) begin
         n = txq.pop_front();
         e = ((n.v == 2'd1) == refp) ? 2'b10 : 2'b01;
         if (n.v == 2'd0) e = 2'b00;
         if (n.md == 2'd0) `CHK("line", n.v, g)
         else if (n.md == 2'd1 && n.v == 2'd3) begin
            `CHK("mark", 1'b1, ^g)
            refp = g[1];
         end else if (n.md == 2'd1) `CHK("line", e, g)
      end
      if (cap && rxq.size() > 0) begin
         s = rxq.pop_front();
         `CHK("rx", s, csym)
      end
      if (cv === 1'b1) cv_cnt++;
      if (ckie === 1'b1) `CHK("inv", ~ck, cki)
   end

   ///////////////////////////////////////////////////////////////////////
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask

   // Three edges of reset; idle levels checked before release
   task automatic rst();
      srst = 1'b1;
      cyc(3);
      `CHK("idle", 6'h3c, {lp_n, ln_n, loc_n, los_n, lq, cv})
      srst = 1'b0;
   endtask

   // One line symbol on a four-cycle recovered clock
   task automatic rx(input sym_s s);
      @(negedge clk);
      rxl = s;
      rrc = 1'b1;
      cyc(2);
      rrc = 1'b0;
      cyc(1);
   endtask

   task automatic final_report();
      if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // Cut a hang short; the tests need about 1700 cycles
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      final_report();
   end

   initial begin
      logic [31:0] r;
      logic [43:0] h;
      logic [18:0] b;
      h = 44'h76544564446; // Marks relative to the first payload mark
      b = 19'b1111_11000010000_1111;
      rst();
      cyc(2);
      `CHK("oe", 4'hf, {rpe, rne, cke, ckie})
      for (int i = 0; i < 16; i++) begin
         r = xs();
         txq.push_back({2'd0, r[1], r[0] & ~r[1]});
         u_term.send(r[1], r[0] & ~r[1]);
      end
      rxq.push_back('0);
      for (int i = 0; i < 12; i++) begin
         r = xs();
         if (i < 11) rxq.push_back(r[1:0]);
         rx(r[1:0]);
      end
      cyc(4);
      `CHK("rxn", 1'b1, rxq.size() == 0)
      `CHK("cvr", 0, cv_cnt)
      rai_n = 1'b0;
      for (int i = 0; i < 6; i++) begin
         refc = 1'b1;
         cyc(3);
         `CHK("aisck", 1'b1, ck)
         refc = 1'b0;
         cyc(3);
         `CHK("aisck", 1'b0, ck)
         if (i > 0) `CHK("ais", 1'b1, rp ^ rn)
      end
      rai_n = 1'b1;
      tai_n = 1'b0;
      for (int i = 0; i < 14; i++) begin
         txq.push_back(i < 6 ? 4'h8 : (i == 6 ? 4'h7 : {2'd1, 2'd1 + i[0]}));
         u_term.send(1'b0, 1'b0);
      end
      tai_n = 1'b1;
      dis_n = 1'b0;
      cyc(3);
      `CHK("oe", 4'h0, {rpe, rne, cke, ckie})
      dis_n = 1'b1;
      u_term.send(1'b0, 1'b0);
      cyc(18);
      `CHK("loc", 1'b1, loc_n)
      cyc(16);
      `CHK("loc", 1'b0, loc_n)
      u_term.send(1'b0, 1'b0);
      `CHK("loc", 1'b1, loc_n)
      rx(2'b10);
      repeat (18) rx('0);
      `CHK("los", 1'b1, los_n)
      repeat (16) rx('0);
      `CHK("los", 1'b0, los_n)
      rx(2'b10);
      `CHK("los", 1'b1, los_n)
      lbr_n = 1'b0;
      r = xs();
      rx(r[1:0]);
      `CHK("rlb", r[1:0], {~lp_n, ~ln_n})
      lbr_n = 1'b1;
      rail_n = 1'b1;
      rst();
      cyc(2);
      `CHK("oe", 2'b00, {rne, ckie})
      for (int i = 0; i < 19; i++) begin
         txq.push_back(i < 8 ? 4'h8 : h[4 * (18 - i) +: 4]);
         u_term.send(b[18 - i], 1'b0);
      end
      cv_cnt = 0;
      repeat (150) rx(2'b10);
      `CHK("lq", 1'b1, lq)
      for (int i = 0; i < 150; i++) rx({i[0], ~i[0]});
      `CHK("lq", 1'b0, lq)
      `CHK("cv", 1'b1, cv_cnt >= 149 && cv_cnt <= 150)
      final_report();
   end
endmodule
